// file: flash_prog_pkg.sv
/*
  Constants for the flash program access register block: register indices
  for the host mailbox and controller mapped space, field positions, resets.
  Assumes the host mailbox and the controller bus deliver 8-bit accesses
  synchronous to ref_clk.
*/
// Functional notes
// (RQ1) flash reset bit one holds flash in reset; zero gives read-array mode.
// (RQ2) flash reset bit is kept until software writes it again.
// (RQ3) boot-protect bit reads one while its low-active pin is low; boot block locked.
// (RQ4) external-code bit reads the inverse of its low-active pin.
// (RQ5) external-code bit set disables flash programming for every requester.
// (RQ6) tester-program bit follows its pin; then programming belongs to tester only.
// (RQ7) tester and external-code bits are read-only, untouched by power-on reset.
// (RQ8) host enable may set only with tester, controller enable, flash disable zero.
// (RQ9) host enable gives flash to host path; read/write, cleared at reset.
// (RQ10) controller enable may set only without tester bit; it beats host enable.
// (RQ11) controller enable gives flash to controller path; read/write, reset clears.
// (RQ12) control register always reachable by host index and controller address.
// (RQ13) while controller owns registers, host writes ignored, host reads still answered.
// (RQ14) host data read under controller ownership returns register, no flash read.
// (RQ15) while host owns registers, controller access is blocked.
// (RQ16) host must halt the controller before programming through these registers.
// (RQ17) high address register holds bits 15..8, read/write, resets to zero.
// (RQ18) low address register holds bits 7..0, read/write, resets to zero.
// (RQ19) data register carries array data, commands or status of the flash.
// (RQ20) programmer loads both address registers before touching the data register.
// (RQ21) refused enable set leaves that bit zero; other written bits still apply.
package flash_prog_pkg;
  localparam logic [7:0] host_idx_control = 8'h9e;
  localparam logic [7:0] host_idx_addr_high = 8'h9f;
  localparam logic [7:0] host_idx_addr_low = 8'h80;
  localparam logic [7:0] host_idx_data = 8'h81;
  localparam logic [15:0] ctl_addr_control = 16'h7f35;
  localparam logic [15:0] ctl_addr_addr_high = 16'h7fb0;
  localparam logic [15:0] ctl_addr_addr_low = 16'h7fb1;
  localparam logic [15:0] ctl_addr_data = 16'h7fb2;
  localparam int bit_flash_reset = 7;
  localparam int bit_boot_protect = 4;
  localparam int bit_external_code = 3;
  localparam int bit_tester = 2;
  localparam int bit_host_en = 1;
  localparam int bit_ctl_en = 0;
  localparam logic [7:0] reg_reset = 8'h00;
  typedef enum logic [2:0] {
    reg_none, reg_control, reg_addr_high, reg_addr_low, reg_data
  } reg_sel_t;
  typedef enum {own_idle, own_tester, own_controller, own_host, own_disabled} owner_t;
endpackage : flash_prog_pkg

// file: flash_prog_decode.sv
/*
  Address decoder shared by both register ports: maps a host mailbox index
  or a controller mapped address onto a register selector.
  Assumes combinational use inside the register block.
*/
`timescale 1ns/100ps
module flash_prog_decode
  import flash_prog_pkg::*;
(
  input wire logic [7:0] host_index,
  input wire logic [15:0] ctl_addr,
  output reg_sel_t host_sel,
  output reg_sel_t ctl_sel
);
  always_comb begin
    case (host_index)
      host_idx_control: host_sel = reg_control;
      host_idx_addr_high: host_sel = reg_addr_high;
      host_idx_addr_low: host_sel = reg_addr_low;
      host_idx_data: host_sel = reg_data;
      default: host_sel = reg_none;
    endcase
  end

  always_comb begin
    case (ctl_addr)
      ctl_addr_control: ctl_sel = reg_control;
      ctl_addr_addr_high: ctl_sel = reg_addr_high;
      ctl_addr_addr_low: ctl_sel = reg_addr_low;
      ctl_addr_data: ctl_sel = reg_data;
      default: ctl_sel = reg_none;
    endcase
  end
endmodule : flash_prog_decode

// file: flash_program_access_regs.sv
/*
  Flash program access registers: ownership control, flash reset, pin
  mirrors, address and data registers, reached from the host mailbox and
  from the controller mapped bus. Flash command interface strobes out.
  Assumes all inputs synchronous to ref_clk and single-cycle access strobes;
  pins sampled once so status and ownership see one consistent value.
*/
`timescale 1ns/100ps
module flash_program_access_regs
  import flash_prog_pkg::*;
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic boot_protect_in_n,
  input wire logic external_code_in_n,
  input wire logic tester_program_in,
  input wire logic system_flash_disable,
  input wire logic host_wr,
  input wire logic host_rd,
  input wire logic [7:0] host_index,
  input wire logic [7:0] host_wdata,
  output logic [7:0] host_rdata,
  output logic host_rvalid,
  input wire logic ctl_wr,
  input wire logic ctl_rd,
  input wire logic [15:0] ctl_addr,
  input wire logic [7:0] ctl_wdata,
  output logic [7:0] ctl_rdata,
  output logic ctl_rvalid,
  input wire logic [7:0] flash_rdata,
  output logic flash_reset,
  output logic boot_block_protect,
  output logic flash_prog_enable,
  output logic host_path_sel,
  output logic ctl_path_sel,
  output logic tester_path_sel,
  output logic [15:0] flash_addr,
  output logic [7:0] flash_wdata,
  output logic flash_wr_stb,
  output logic flash_rd_stb
);
  logic rst_sync1_reg;
  logic rst_sync2_reg;
  logic rst_n;
  logic boot_protect_reg;
  logic external_code_reg;
  logic tester_reg;
  logic flash_reset_reg;
  logic host_en_reg;
  logic ctl_en_reg;
  logic [7:0] addr_high_reg;
  logic [7:0] addr_low_reg;
  logic [7:0] data_reg;
  logic data_load_reg;
  reg_sel_t host_sel;
  reg_sel_t ctl_sel;
  owner_t owner;
  logic host_wr_ok;
  logic ctl_wr_ok;
  logic ctl_rd_ok;
  logic host_data_rd;
  logic ctl_data_rd;
  logic wr_any;
  reg_sel_t wr_sel;
  logic [7:0] wr_data;
  logic [7:0] control_view;
  logic host_en_next;
  logic ctl_en_next;

  function automatic logic [7:0] read_mux(input reg_sel_t sel, input logic [7:0] ctrl,
      input logic [7:0] hi, input logic [7:0] lo, input logic [7:0] dat);
    case (sel)
      reg_control: read_mux = ctrl;
      reg_addr_high: read_mux = hi;
      reg_addr_low: read_mux = lo;
      reg_data: read_mux = dat;
      default: read_mux = reg_reset;
    endcase
  endfunction : read_mux

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rst_sync1_reg <= 1'b0;
      rst_sync2_reg <= 1'b0;
    end else begin
      rst_sync1_reg <= 1'b1;
      rst_sync2_reg <= rst_sync1_reg;
    end
  end
  assign rst_n = rst_sync2_reg;

  flash_prog_decode u_decode (
    .host_index(host_index),
    .ctl_addr(ctl_addr),
    .host_sel(host_sel),
    .ctl_sel(ctl_sel)
  );

  // pin mirrors run free of reset so they never lose the pin state
  always_ff @(posedge ref_clk) begin
    boot_protect_reg <= ~boot_protect_in_n; // see (RQ3)
    external_code_reg <= ~external_code_in_n; // see (RQ4) see (RQ7)
    tester_reg <= tester_program_in; // see (RQ6) see (RQ7)
  end

  // external code beats everything, tester next, controller over host
  always_comb begin
    if (external_code_reg) begin
      owner = own_disabled; // see (RQ5)
    end else if (tester_reg) begin
      owner = own_tester; // see (RQ6)
    end else if (ctl_en_reg) begin
      owner = own_controller; // see (RQ10) see (RQ11)
    end else if (host_en_reg) begin
      owner = own_host; // see (RQ9)
    end else begin
      owner = own_idle;
    end
  end

  // control register is open to both sides whatever the ownership
  always_comb begin
    host_wr_ok = host_wr && (host_sel == reg_control ||
                 (host_sel != reg_none && owner != own_controller)); // see (RQ12) see (RQ13)
    ctl_wr_ok = ctl_wr && (ctl_sel == reg_control ||
                (ctl_sel != reg_none && owner != own_host)); // see (RQ12) see (RQ15)
    ctl_rd_ok = ctl_rd && (ctl_sel == reg_control || owner != own_host); // see (RQ15)
    host_data_rd = host_rd && host_sel == reg_data && owner == own_host; // see (RQ14)
    ctl_data_rd = ctl_rd_ok && ctl_sel == reg_data && owner == own_controller;
  end

  // controller wins a same-cycle collision; host is normally halted then
  always_comb begin
    wr_any = ctl_wr_ok || host_wr_ok;
    wr_sel = ctl_wr_ok ? ctl_sel : (host_wr_ok ? host_sel : reg_none);
    wr_data = ctl_wr_ok ? ctl_wdata : host_wdata;
  end

  always_comb begin
    control_view = reg_reset;
    control_view[bit_flash_reset] = flash_reset_reg;
    control_view[bit_boot_protect] = boot_protect_reg;
    control_view[bit_external_code] = external_code_reg;
    control_view[bit_tester] = tester_reg;
    control_view[bit_host_en] = host_en_reg;
    control_view[bit_ctl_en] = ctl_en_reg;
  end

  // a refused enable simply stays zero, the rest of the byte lands
  always_comb begin
    ctl_en_next = wr_data[bit_ctl_en] && !tester_reg; // see (RQ10) see (RQ21)
    host_en_next = wr_data[bit_host_en] && !tester_reg && !ctl_en_next &&
                   !system_flash_disable; // see (RQ8) see (RQ21)
  end

  // no self-clear: only a control write moves the flash reset bit
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      flash_reset_reg <= 1'b0;
    end else if (wr_any && wr_sel == reg_control) begin
      flash_reset_reg <= wr_data[bit_flash_reset]; // see (RQ1) see (RQ2)
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctl_en_reg <= 1'b0;
    end else if (wr_any && wr_sel == reg_control) begin
      ctl_en_reg <= ctl_en_next; // see (RQ11)
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      host_en_reg <= 1'b0;
    end else if (wr_any && wr_sel == reg_control) begin
      host_en_reg <= host_en_next; // see (RQ9)
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      addr_high_reg <= reg_reset;
    end else if (wr_any && wr_sel == reg_addr_high) begin
      addr_high_reg <= wr_data; // see (RQ17)
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      addr_low_reg <= reg_reset;
    end else if (wr_any && wr_sel == reg_addr_low) begin
      addr_low_reg <= wr_data; // see (RQ18)
    end
  end

  // load flag rises with the flash read strobe so the flash answer is taken a cycle after the read request
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      data_load_reg <= 1'b0;
    end else begin
      data_load_reg <= host_data_rd || ctl_data_rd;
    end
  end

  // data register captures any accepted write from either side and flash read results of the owner
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      data_reg <= reg_reset;
    end else if (wr_any && wr_sel == reg_data) begin
      data_reg <= wr_data; // see (RQ19)
    end else if (data_load_reg) begin
      data_reg <= flash_rdata; // see (RQ19)
    end
  end

  // flash strobes go out only for the party that owns the path
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      flash_wr_stb <= 1'b0;
    end else begin
      flash_wr_stb <= wr_any && wr_sel == reg_data &&
                      ((ctl_wr_ok && owner == own_controller) ||
                       (!ctl_wr_ok && owner == own_host)); // see (RQ13)
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      flash_rd_stb <= 1'b0;
    end else begin
      flash_rd_stb <= host_data_rd || ctl_data_rd; // see (RQ14)
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      flash_wdata <= reg_reset;
    end else if (wr_any && wr_sel == reg_data) begin
      flash_wdata <= wr_data;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      flash_reset <= 1'b0;
      boot_block_protect <= 1'b0;
    end else begin
      flash_reset <= flash_reset_reg; // see (RQ1)
      boot_block_protect <= boot_protect_reg; // see (RQ3)
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      flash_prog_enable <= 1'b0;
    end else begin
      flash_prog_enable <= owner != own_disabled; // see (RQ5)
    end
  end

  // path selects are at most one-hot (all zero when idle or disabled) because they all decode the same owner
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      host_path_sel <= 1'b0;
      ctl_path_sel <= 1'b0;
      tester_path_sel <= 1'b0;
    end else begin
      host_path_sel <= owner == own_host; // see (RQ9)
      ctl_path_sel <= owner == own_controller; // see (RQ11)
      tester_path_sel <= owner == own_tester; // see (RQ6)
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      flash_addr <= {reg_reset, reg_reset};
    end else begin
      flash_addr <= {addr_high_reg, addr_low_reg};
    end
  end

  // host reads always answer, even when the controller owns the registers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      host_rdata <= reg_reset;
      host_rvalid <= 1'b0;
    end else begin
      host_rvalid <= host_rd;
      if (host_rd) begin
        host_rdata <= read_mux(host_sel, control_view, addr_high_reg, addr_low_reg,
                               data_reg); // see (RQ13)
      end
    end
  end

  // a blocked controller read still answers, with zero, so it never stalls
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctl_rdata <= reg_reset;
      ctl_rvalid <= 1'b0;
    end else begin
      ctl_rvalid <= ctl_rd;
      if (ctl_rd) begin
        ctl_rdata <= ctl_rd_ok ? read_mux(ctl_sel, control_view, addr_high_reg,
                                          addr_low_reg, data_reg) : reg_reset; // see (RQ15)
      end
    end
  end
endmodule : flash_program_access_regs

// file: flash_array_model.sv
/*
  Behavioural embedded flash: byte array on the low address byte.
  Assumes strobes from the register block, all on ref_clk.
*/
`timescale 1ns/100ps
module flash_array_model (
  input wire logic ref_clk,
  input wire logic flash_reset,
  input wire logic [15:0] flash_addr,
  input wire logic [7:0] flash_wdata,
  input wire logic flash_wr_stb,
  input wire logic flash_rd_stb,
  output logic [7:0] flash_rdata
);
  logic [7:0] mem [256];
  logic [7:0] last_reg;
  logic hold_reg;
  always_ff @(posedge ref_clk) begin
    if (flash_wr_stb && !flash_reset)
      mem[flash_addr[7:0]] <= flash_wdata;
    hold_reg <= flash_rd_stb;
    if (flash_rd_stb)
      last_reg <= mem[flash_addr[7:0]];
  end
  // after the hold cycle the bus is released: inverse so stale data never matches
  assign flash_rdata = flash_rd_stb ? mem[flash_addr[7:0]] : (hold_reg ? last_reg : ~last_reg);
endmodule : flash_array_model

// file: flash_prog_asserts.sv
/*
  Port-level checker for the flash program access registers.
  Assumes it is bound onto the top module; one clock domain.
*/
`timescale 1ns/100ps
module flash_prog_asserts
  import flash_prog_pkg::*;
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic boot_protect_in_n,
  input wire logic external_code_in_n,
  input wire logic tester_program_in,
  input wire logic host_wr,
  input wire logic host_rd,
  input wire logic [7:0] host_index,
  input wire logic ctl_wr,
  input wire logic ctl_rd,
  input wire logic [15:0] ctl_addr,
  input wire logic host_rvalid,
  input wire logic ctl_rvalid,
  input wire logic [7:0] ctl_rdata,
  input wire logic flash_reset,
  input wire logic boot_block_protect,
  input wire logic flash_prog_enable,
  input wire logic host_path_sel,
  input wire logic ctl_path_sel,
  input wire logic tester_path_sel,
  input wire logic flash_rd_stb
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  // internal reset runs two edges past nrst: hold off until outputs are live
  logic [1:0] up_reg;
  logic live;
  logic wr_any;
  always_ff @(posedge ref_clk or negedge nrst)
    if (!nrst) up_reg <= 2'h0;
    else if (up_reg != 2'h3) up_reg <= up_reg + 2'h1;
  assign live = up_reg == 2'h3;
  assign wr_any = host_wr || ctl_wr;
  sequence s_boot_low; (live && !boot_protect_in_n) [*4]; endsequence
  sequence s_ext_low; (live && !external_code_in_n) [*4]; endsequence
  sequence s_tester; (live && tester_program_in && external_code_in_n) [*4]; endsequence
  sequence s_host_data_rd;
    host_rd && host_index == host_idx_data && ctl_path_sel && !ctl_rd && !$past(wr_any);
  endsequence
  AST_BOOT: assert property (s_boot_low |-> boot_block_protect)
    else $error("boot protect not raised");
  AST_EXT: assert property (s_ext_low |-> !flash_prog_enable && !host_path_sel)
    else $error("programming left enabled under external code");
  AST_TESTER: assert property (s_tester |-> tester_path_sel && !ctl_path_sel)
    else $error("tester path not exclusive");
  AST_ONE_PATH: assert property (live |->
      $onehot0({host_path_sel, ctl_path_sel, tester_path_sel}))
    else $error("more than one path selected");
  AST_RVALID: assert property (live |->
      {host_rvalid, ctl_rvalid} == $past({host_rd, ctl_rd}))
    else $error("read answer not one cycle after request");
  // a later controller read may legally strobe the flash, so look one cycle only
  AST_NO_FLASH_RD: assert property (s_host_data_rd |=> !flash_rd_stb)
    else $error("host read started a flash read");
  // path selects lag the owner: no write or pin change just before the read
  AST_CTL_BLOCK: assert property (host_path_sel && !$past(wr_any) &&
      ctl_rd && ctl_addr == ctl_addr_addr_low &&
      $past(external_code_in_n) && !$past(tester_program_in) |=> ctl_rdata == 8'h00)
    else $error("controller read not blocked");
  AST_RESET_HOLD: assert property (live && !$past(wr_any) &&
      !$past(wr_any, 2) |-> $stable(flash_reset))
    else $error("flash reset changed without a write");
endmodule : flash_prog_asserts
bind flash_program_access_regs flash_prog_asserts checker_inst (.*);

// file: flash_program_access_regs_tb.sv
/*
  Self-checking bench: host and controller register accesses in sequence.
  Assumes the flash model on the far side and a 50 MHz clock.
*/
`timescale 1ns/100ps
module flash_program_access_regs_tb;
  import flash_prog_pkg::*;
  logic ref_clk, nrst, boot_protect_in_n, external_code_in_n, tester_program_in;
  logic system_flash_disable, host_wr, host_rd, ctl_wr, ctl_rd, host_rvalid, ctl_rvalid;
  logic flash_reset, boot_block_protect, flash_prog_enable, host_path_sel, ctl_path_sel;
  logic tester_path_sel, flash_wr_stb, flash_rd_stb;
  logic [7:0] host_index, host_wdata, host_rdata, ctl_wdata, ctl_rdata, flash_rdata, flash_wdata;
  logic [15:0] ctl_addr, flash_addr;
  int mismatches, samples_checked, cycles;
  flash_program_access_regs DUT (.*);
  flash_array_model flash (.ref_clk, .flash_reset, .flash_addr, .flash_wdata, .flash_wr_stb,
    .flash_rd_stb, .flash_rdata);
  always #10 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      test_done();
    end
  end
  task automatic test_done;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : test_done
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input bit h, input logic [15:0] a, input logic [7:0] d);
    if (h) {host_wr, host_index, host_wdata} <= {1'b1, a[7:0], d};
    else {ctl_wr, ctl_addr, ctl_wdata} <= {1'b1, a, d};
    @(posedge ref_clk);
    {host_wr, ctl_wr} <= 2'h0;
    @(posedge ref_clk);
  endtask : wr
  task automatic rd(input bit h, input logic [15:0] a, input logic [7:0] e);
    if (h) {host_rd, host_index} <= {1'b1, a[7:0]};
    else {ctl_rd, ctl_addr} <= {1'b1, a};
    @(posedge ref_clk);
    {host_rd, ctl_rd} <= 2'h0;
    #1 chk(h ? {15'h0, host_rvalid, host_rdata} : {15'h0, ctl_rvalid, ctl_rdata}, {16'h1, e});
    @(posedge ref_clk);
  endtask : rd
  task automatic outs(input logic [5:0] e);
    repeat (2) @(posedge ref_clk);
    #1 chk({flash_addr, 2'h0, flash_prog_enable, flash_reset, boot_block_protect,
      host_path_sel, ctl_path_sel, tester_path_sel}, {16'h1234, 2'h0, e});
    @(posedge ref_clk);
  endtask : outs
  initial begin
    {ref_clk, nrst, host_wr, host_rd, ctl_wr, ctl_rd, system_flash_disable} = '0;
    {tester_program_in, host_index, host_wdata, ctl_wdata, ctl_addr} = '0;
    {boot_protect_in_n, external_code_in_n} = 2'h3;
    {mismatches, samples_checked, cycles} = '0;
    repeat (4) @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rd(1, host_idx_control, 8'h00);
    rd(1, host_idx_addr_high, 8'h00);
    rd(0, ctl_addr_addr_low, 8'h00);
    rd(0, ctl_addr_data, 8'h00);
    rd(1, 8'h00, 8'h00);
    wr(1, host_idx_control, 8'h80);
    wr(1, host_idx_addr_high, 8'h12);
    wr(1, host_idx_addr_low, 8'h34);
    outs(6'h30);
    wr(1, host_idx_control, 8'h00);
    outs(6'h20);
    boot_protect_in_n <= 1'b0;
    outs(6'h28);
    rd(1, host_idx_control, 8'h10);
    boot_protect_in_n <= 1'b1;
    external_code_in_n <= 1'b0;
    wr(1, host_idx_control, 8'h02);
    outs(6'h00);
    rd(1, host_idx_control, 8'h0a);
    wr(1, host_idx_control, 8'h00);
    external_code_in_n <= 1'b1;
    tester_program_in <= 1'b1;
    outs(6'h21);
    wr(1, host_idx_control, 8'h83);
    rd(1, host_idx_control, 8'h84);
    outs(6'h31);
    wr(0, ctl_addr_control, 8'h00);
    tester_program_in <= 1'b0;
    system_flash_disable <= 1'b1;
    wr(1, host_idx_control, 8'h02);
    rd(1, host_idx_control, 8'h00);
    system_flash_disable <= 1'b0;
    wr(1, host_idx_control, 8'h02);
    outs(6'h24);
    rd(0, ctl_addr_control, 8'h02);
    wr(0, ctl_addr_addr_low, 8'h77);
    rd(0, ctl_addr_addr_low, 8'h00);
    rd(1, host_idx_addr_low, 8'h34);
    // controller stays quiet while the host programs
    wr(1, host_idx_data, 8'h5a);
    rd(1, host_idx_data, 8'h5a);
    wr(0, ctl_addr_control, 8'h03);
    rd(1, host_idx_control, 8'h01);
    outs(6'h22);
    wr(1, host_idx_addr_high, 8'hff);
    rd(1, host_idx_addr_high, 8'h12);
    rd(1, host_idx_data, 8'h5a);
    wr(0, ctl_addr_addr_low, 8'h35);
    wr(0, ctl_addr_data, 8'ha5);
    wr(0, ctl_addr_addr_low, 8'h34);
    rd(0, ctl_addr_data, 8'ha5);
    rd(0, ctl_addr_data, 8'h5a);
    // pin mirrors must survive a reset in mid-run
    tester_program_in <= 1'b1;
    nrst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rd(1, host_idx_control, 8'h04);
    rd(1, host_idx_addr_low, 8'h00);
    test_done();
  end
endmodule : flash_program_access_regs_tb
